// ### logic/plm_pixel_core.v
// Pixel path: four lookup tables (luma, red, green, blue), then
// two colour-matrix units (RGB-to-RGB, then RGB-to-luma/chroma), and
// the register port that configures them.
// Assumes pixels on the core clock with no back-pressure and
// software on the one-cycle strobe port.
//
// Notes on behaviour
// - Table choice picks which table controls address
// - Single-table build ignores choice, uses table
// - Per-table activation flag switches table into path
// - Per-table position picks entry for word access
// - Word access reads or replaces positioned entry
// - Window accesses every entry, ignoring position
// - Matrix takes a three-component pixel as input
// - Output is gain matrix product plus offsets
// - Row names output, column names input component
// - Offset n is added to output n
// - Second unit usable as luma/chroma converter
// - Unit choice picks which unit is configured
// - Per-unit activation flag switches unit into path
// - Element choice picks one of twelve coefficients
// - Element word reads or writes chosen coefficient
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "plm_map.vh"

module plm_pixel_core
#(
   parameter SINGLE_TABLE = 0
)
(
   input wire I_CORE_CLK,
   input wire I_RST_B,
   input wire [`PLM_AW-1:0] I_REG_ADDR,
   input wire [`PLM_DW-1:0] I_REG_WDATA,
   input wire I_REG_WR,
   input wire I_REG_RD,
   output wire [`PLM_DW-1:0] O_REG_RDATA,
   input wire I_PIX_VALID,
   input wire [`PLM_PIX_W-1:0] I_PIX_C0,
   input wire [`PLM_PIX_W-1:0] I_PIX_C1,
   input wire [`PLM_PIX_W-1:0] I_PIX_C2,
   output wire O_PIX_VALID,
   output wire [`PLM_PIX_W-1:0] O_PIX_C0,
   output wire [`PLM_PIX_W-1:0] O_PIX_C1,
   output wire [`PLM_PIX_W-1:0] O_PIX_C2
);

   // Exact match of a word register; the window is excluded
   function reg_hit;
      input [`PLM_AW-1:0] addr;
      input [`PLM_AW-1:0] offs;
      begin
         reg_hit = (addr == offs);
      end
   endfunction

   // Reset value of coefficient slot k (0..11 RGB unit, 12..23 luma unit)
   function [`PLM_COEF_W-1:0] coef_reset;
      input [4:0] k;
      begin
         case (k)
            5'h00, 5'h04, 5'h08: coef_reset = `PLM_UNITY; // Identity diagonal
            5'h0C: coef_reset = `PLM_YUV_G00; // Luma row
            5'h0D: coef_reset = `PLM_YUV_G01;
            5'h0E: coef_reset = `PLM_YUV_G02;
            5'h0F: coef_reset = `PLM_YUV_G10; // First chroma row
            5'h10: coef_reset = `PLM_YUV_G11;
            5'h11: coef_reset = `PLM_YUV_G12;
            5'h12: coef_reset = `PLM_YUV_G20; // Second chroma row
            5'h13: coef_reset = `PLM_YUV_G21;
            5'h14: coef_reset = `PLM_YUV_G22;
            5'h16, 5'h17: coef_reset = `PLM_YUV_OFS_CHROMA; // Chroma mid-code
            default: coef_reset = 16'h0000;
         endcase
      end
   endfunction

   // Software-visible control state
   reg [1:0] table_choice_ff; // Table the per-table controls act on
   reg [3:0] table_act_ff; // One activation flag per table
   reg [7:0] coef_pos_ff [0:3]; // One coefficient position per table
   reg unit_choice_ff; // Matrix unit being configured
   reg [1:0] unit_act_ff; // One activation flag per unit
   reg [3:0] elem_choice_ff [0:1]; // Element choice, one per unit
   reg [`PLM_COEF_W-1:0] coef_ff [0:`PLM_NUM_COEF-1]; // Gains and offsets
   reg [`PLM_DW-1:0] rdata_ff; // Read data, valid the cycle after a read
   reg [`PLM_DW-1:0] nxt_rdata; // Read mux result

   // Decoded accesses
   wire bulk_sel; // Whole-table window addressed
   wire [7:0] bulk_idx; // Entry index inside the window
   wire [1:0] tbl; // Effective table choice
   wire [7:0] sw_idx; // Entry addressed by software
   wire [3:0] elem_cur; // Element choice of the chosen unit
   wire [4:0] coef_idx; // Flat coefficient slot being accessed
   wire lut_wr; // Software writes a table entry
   wire [7:0] lut_sw_rd [0:3]; // Software read data of each table

   // Pixel pipeline
   reg s1_v_ff; // Stage 1: after luma table
   reg [7:0] s1_c_ff [0:2];
   reg s2_v_ff; // Stage 2: after colour tables
   reg [7:0] s2_c_ff [0:2];
   wire [23:0] luma_in; // Incoming triplet into the luma table
   wire [23:0] luma_out; // Luma table results for all three components
   wire [23:0] col_out [1:3]; // Colour table results (low byte used)
   wire [`PLM_BUS_W-1:0] coef_bus; // Flattened coefficients for both units
   wire m1_v; // RGB-to-RGB unit output
   wire [7:0] m1_c0;
   wire [7:0] m1_c1;
   wire [7:0] m1_c2;

   integer i;

   // Window decode: bit 10 set selects the whole-table window
   assign bulk_sel = I_REG_ADDR[`PLM_BULK_BIT];
   assign bulk_idx = I_REG_ADDR[`PLM_IDX_MSB:`PLM_IDX_LSB];

   // A single-table build has no choice; everything acts on table 0
   assign tbl = (SINGLE_TABLE != 0) ? `PLM_TBL_LUMA : table_choice_ff;

   // Window ignores the position; word access uses the chosen position
   assign sw_idx = bulk_sel ? bulk_idx : coef_pos_ff[tbl];

   // Only the chosen table takes the write
   assign lut_wr = I_REG_WR & (bulk_sel | reg_hit(I_REG_ADDR, `PLM_REG_COEF_WORD));

   // Element slot inside the chosen unit's twelve coefficients
   assign elem_cur = elem_choice_ff[unit_choice_ff];
   assign coef_idx = unit_choice_ff ? (`PLM_UNIT_STRIDE + {1'b0, elem_cur}) : {1'b0, elem_cur};

   // Register writes; a write to an unmapped address is dropped
   always @(posedge I_CORE_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         table_choice_ff <= 2'h0;
         table_act_ff <= 4'h0;
         unit_choice_ff <= `PLM_UNIT_RGB;
         unit_act_ff <= 2'h0;
         for (i = 0; i < `PLM_NUM_TABLES; i = i + 1)
            coef_pos_ff[i] <= 8'h00;
         for (i = 0; i < 2; i = i + 1)
            elem_choice_ff[i] <= 4'h0;
         // Luma unit starts as the typical 8-bit converter
         for (i = 0; i < `PLM_NUM_COEF; i = i + 1)
            coef_ff[i] <= coef_reset(i[4:0]);
      end
      else if (I_REG_WR && !bulk_sel)
      begin
         if (reg_hit(I_REG_ADDR, `PLM_REG_TABLE_CHOICE))
         begin
            // Single-table build keeps the choice at zero
            table_choice_ff <= (SINGLE_TABLE != 0) ? `PLM_TBL_LUMA : I_REG_WDATA[1:0];
         end
         if (reg_hit(I_REG_ADDR, `PLM_REG_TABLE_ACTIVATE))
         begin
            table_act_ff[tbl] <= I_REG_WDATA[0];
         end
         if (reg_hit(I_REG_ADDR, `PLM_REG_COEF_POSITION))
         begin
            coef_pos_ff[tbl] <= I_REG_WDATA[7:0];
         end
         if (reg_hit(I_REG_ADDR, `PLM_REG_UNIT_CHOICE))
         begin
            unit_choice_ff <= I_REG_WDATA[0];
         end
         if (reg_hit(I_REG_ADDR, `PLM_REG_UNIT_ACTIVATE))
         begin
            unit_act_ff[unit_choice_ff] <= I_REG_WDATA[0];
         end
         // Codes above the last offset name nothing and are ignored
         if (reg_hit(I_REG_ADDR, `PLM_REG_ELEM_CHOICE) && I_REG_WDATA[3:0] <= `PLM_ELEM_LAST
            && I_REG_WDATA[31:4] == 28'h0000000)
         begin
            elem_choice_ff[unit_choice_ff] <= I_REG_WDATA[3:0];
         end
         if (reg_hit(I_REG_ADDR, `PLM_REG_ELEM_WORD))
         begin
            coef_ff[coef_idx] <= I_REG_WDATA[15:0];
         end
      end
   end

   // Read mux; unmapped addresses and reserved bits read as zero
   always @*
   begin
      nxt_rdata = 32'h00000000;
      if (bulk_sel)
         nxt_rdata = {24'h000000, lut_sw_rd[tbl]};
      else
      begin
         case (I_REG_ADDR)
            `PLM_REG_TABLE_CHOICE: nxt_rdata = {30'h00000000, tbl};
            `PLM_REG_TABLE_ACTIVATE: nxt_rdata = {31'h00000000, table_act_ff[tbl]};
            `PLM_REG_COEF_POSITION: nxt_rdata = {24'h000000, coef_pos_ff[tbl]};
            `PLM_REG_COEF_WORD: nxt_rdata = {24'h000000, lut_sw_rd[tbl]};
            `PLM_REG_UNIT_CHOICE: nxt_rdata = {31'h00000000, unit_choice_ff};
            `PLM_REG_UNIT_ACTIVATE: nxt_rdata = {31'h00000000, unit_act_ff[unit_choice_ff]};
            `PLM_REG_ELEM_CHOICE: nxt_rdata = {28'h0000000, elem_cur};
            // Coefficients are signed; reads sign-extend them
            `PLM_REG_ELEM_WORD: nxt_rdata = {{16{coef_ff[coef_idx][15]}}, coef_ff[coef_idx]};
            // Live activation state of every table and unit
            `PLM_REG_STATUS: nxt_rdata = {26'h0000000, unit_act_ff, table_act_ff};
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end

   // Read data stand one cycle after the strobe, else zero
   always @(posedge I_CORE_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         rdata_ff <= 32'h00000000;
      else if (I_REG_RD)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= 32'h00000000;
   end

   assign O_REG_RDATA = rdata_ff;

   // Luma table sees all three incoming components
   assign luma_in = {I_PIX_C2, I_PIX_C1, I_PIX_C0};

   // Four table instances: table 0 luma, tables 1..3 red, green, blue
   genvar t;
   generate
      for (t = 0; t < `PLM_NUM_TABLES; t = t + 1)
      begin : g_tbl
         wire [23:0] pix_idx;
         wire [23:0] pix_dat;
         if (t == 0)
         begin : g_luma
            assign pix_idx = luma_in;
            assign luma_out = pix_dat;
         end
         else
         begin : g_col
            // Each colour table serves only its own component
            assign pix_idx = {16'h0000, s1_c_ff[t-1]};
            assign col_out[t] = pix_dat;
         end
         plm_lut_ram u_lut
         (
            .i_clk(I_CORE_CLK),
            .i_wr(lut_wr && (tbl == t)),
            .i_wr_idx(sw_idx),
            .i_wr_data(I_REG_WDATA[7:0]),
            .i_sw_idx(sw_idx),
            .o_sw_data(lut_sw_rd[t]),
            .i_pix_idx(pix_idx),
            .o_pix_data(pix_dat)
         );
      end
   endgenerate

   // Stage 1: luma table, applied to every component when active
   always @(posedge I_CORE_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         s1_v_ff <= 1'b0;
         for (i = 0; i < 3; i = i + 1)
            s1_c_ff[i] <= 8'h00;
      end
      else
      begin
         s1_v_ff <= I_PIX_VALID;
         if (I_PIX_VALID)
         begin
            for (i = 0; i < 3; i = i + 1)
               s1_c_ff[i] <= table_act_ff[0] ? luma_out[i*8 +: 8] : luma_in[i*8 +: 8];
         end
      end
   end

   // Stage 2: red, green and blue tables each on their own component
   always @(posedge I_CORE_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         s2_v_ff <= 1'b0;
         for (i = 0; i < 3; i = i + 1)
            s2_c_ff[i] <= 8'h00;
      end
      else
      begin
         s2_v_ff <= s1_v_ff;
         if (s1_v_ff)
         begin
            s2_c_ff[0] <= table_act_ff[1] ? col_out[1][7:0] : s1_c_ff[0];
            s2_c_ff[1] <= table_act_ff[2] ? col_out[2][7:0] : s1_c_ff[1];
            s2_c_ff[2] <= table_act_ff[3] ? col_out[3][7:0] : s1_c_ff[2];
         end
      end
   end

   // Flatten coefficient storage for the two units
   genvar k;
   generate
      for (k = 0; k < `PLM_NUM_COEF; k = k + 1)
      begin : g_coef
         assign coef_bus[k*`PLM_COEF_W +: `PLM_COEF_W] = coef_ff[k];
      end
   endgenerate

   // Stage 3: RGB-to-RGB unit; coefficients may change mid-frame,
   // so update them between frames to avoid torn pixels
   plm_matrix_unit u_rgb
   (
      .i_clk(I_CORE_CLK),
      .i_rst_b(I_RST_B),
      .i_enable(unit_act_ff[0]),
      .i_valid(s2_v_ff),
      .i_c0(s2_c_ff[0]),
      .i_c1(s2_c_ff[1]),
      .i_c2(s2_c_ff[2]),
      .i_coef(coef_bus[191:0]),
      .o_valid(m1_v),
      .o_c0(m1_c0),
      .o_c1(m1_c1),
      .o_c2(m1_c2)
   );

   // Stage 4: luma/chroma unit on the same datapath, fixed latency
   plm_matrix_unit u_yuv
   (
      .i_clk(I_CORE_CLK),
      .i_rst_b(I_RST_B),
      .i_enable(unit_act_ff[1]),
      .i_valid(m1_v),
      .i_c0(m1_c0),
      .i_c1(m1_c1),
      .i_c2(m1_c2),
      .i_coef(coef_bus[383:192]),
      .o_valid(O_PIX_VALID),
      .o_c0(O_PIX_C0),
      .o_c1(O_PIX_C1),
      .o_c2(O_PIX_C2)
   );

endmodule

// ### logic/plm_map.vh
// Address map, fields, reset values and widths of the
// pixel table and colour-matrix block.
// Assumes inclusion by bare name.
`ifndef PLM_MAP_VH
`define PLM_MAP_VH

// Widths and depths
`define PLM_AW 11
`define PLM_DW 32
`define PLM_PIX_W 8
`define PLM_COEF_W 16
`define PLM_LUT_DEPTH 256
`define PLM_NUM_TABLES 4
`define PLM_NUM_COEF 24
`define PLM_BUS_W 384

// Register offsets (byte addresses, one aligned word each)
`define PLM_REG_TABLE_CHOICE 11'h000
`define PLM_REG_TABLE_ACTIVATE 11'h004
`define PLM_REG_COEF_POSITION 11'h008
`define PLM_REG_COEF_WORD 11'h00C
`define PLM_REG_UNIT_CHOICE 11'h010
`define PLM_REG_UNIT_ACTIVATE 11'h014
`define PLM_REG_ELEM_CHOICE 11'h018
`define PLM_REG_ELEM_WORD 11'h01C
`define PLM_REG_STATUS 11'h020

// Whole-table window: bit 10 set, index in bits 9..2
`define PLM_BULK_BIT 10
`define PLM_IDX_MSB 9
`define PLM_IDX_LSB 2

// Table and unit codes
`define PLM_TBL_LUMA 2'h0
`define PLM_UNIT_RGB 1'h0
`define PLM_UNIT_STRIDE 5'h0C
`define PLM_ELEM_LAST 4'hB

// Fixed-point: gains signed with 8 fraction bits, offsets in pixel codes
`define PLM_FRAC 8
`define PLM_UNITY 16'h0100
`define PLM_ROUND 28'h0000080
`define PLM_PIX_MAX 8'hFF

// Reset values of the luma-chroma unit
`define PLM_YUV_G00 16'h004D
`define PLM_YUV_G01 16'h0096
`define PLM_YUV_G02 16'h001D
`define PLM_YUV_G10 16'hFFDA
`define PLM_YUV_G11 16'hFFB6
`define PLM_YUV_G12 16'h0070
`define PLM_YUV_G20 16'h009D
`define PLM_YUV_G21 16'hFF7C
`define PLM_YUV_G22 16'hFFE6
`define PLM_YUV_OFS_CHROMA 16'h0080

`endif

// ### logic/plm_lut_ram.v
// One lookup table: a software port and three pixel read ports.
// Assumes one core clock; reads are combinational.
`timescale 1ns/1ps
`include "plm_map.vh"

module plm_lut_ram
(
   input wire i_clk,
   input wire i_wr,
   input wire [`PLM_PIX_W-1:0] i_wr_idx,
   input wire [`PLM_PIX_W-1:0] i_wr_data,
   input wire [`PLM_PIX_W-1:0] i_sw_idx,
   output wire [`PLM_PIX_W-1:0] o_sw_data,
   input wire [3*`PLM_PIX_W-1:0] i_pix_idx,
   output wire [3*`PLM_PIX_W-1:0] o_pix_data
);

   // Table storage; no reset, software loads it before enabling
   reg [`PLM_PIX_W-1:0] mem [0:`PLM_LUT_DEPTH-1];

   // Single write port driven from the register side
   always @(posedge i_clk)
   begin
      if (i_wr)
      begin
         mem[i_wr_idx] <= i_wr_data;
      end
   end

   // Software read for word and window access
   assign o_sw_data = mem[i_sw_idx];

   // One pixel read port per component
   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1)
      begin : g_rd
         assign o_pix_data[k*`PLM_PIX_W +: `PLM_PIX_W] = mem[i_pix_idx[k*`PLM_PIX_W +: `PLM_PIX_W]];
      end
   endgenerate

endmodule

// ### logic/plm_matrix_unit.v
// One colour-matrix unit: gain product plus offsets, rounded
// and saturated, one register stage. Coefficients arrive as a flat bus:
// gains row-major in slots 0..8, offsets in slots 9..11.
`timescale 1ns/1ps
`include "plm_map.vh"

module plm_matrix_unit
(
   input wire i_clk,
   input wire i_rst_b,
   input wire i_enable,
   input wire i_valid,
   input wire [`PLM_PIX_W-1:0] i_c0,
   input wire [`PLM_PIX_W-1:0] i_c1,
   input wire [`PLM_PIX_W-1:0] i_c2,
   input wire [12*`PLM_COEF_W-1:0] i_coef,
   output reg o_valid,
   output wire [`PLM_PIX_W-1:0] o_c0,
   output wire [`PLM_PIX_W-1:0] o_c1,
   output wire [`PLM_PIX_W-1:0] o_c2
);

   // Clamp a rounded accumulator to the pixel range
   function [`PLM_PIX_W-1:0] sat_pix;
      input [27:0] acc;
      begin
         if (acc[27])
            sat_pix = 8'h00; // Negative result clamps to zero
         else if (|acc[26:16])
            sat_pix = `PLM_PIX_MAX; // Overflow clamps to full scale
         else
            sat_pix = acc[15:8];
      end
   endfunction

   wire [3*`PLM_PIX_W-1:0] cin; // Input triplet, component 0 lowest
   reg [`PLM_PIX_W-1:0] out_ff [0:2]; // Registered output triplet

   assign cin = {i_c2, i_c1, i_c0};

   // Each row r produces output component r from all three inputs
   genvar r;
   generate
      for (r = 0; r < 3; r = r + 1)
      begin : g_row
         wire signed [15:0] g0 = i_coef[(r*3+0)*`PLM_COEF_W +: `PLM_COEF_W];
         wire signed [15:0] g1 = i_coef[(r*3+1)*`PLM_COEF_W +: `PLM_COEF_W];
         wire signed [15:0] g2 = i_coef[(r*3+2)*`PLM_COEF_W +: `PLM_COEF_W];
         wire [15:0] ofs = i_coef[(9+r)*`PLM_COEF_W +: `PLM_COEF_W];
         // Column index picks the input component
         wire signed [24:0] p0 = $signed({1'b0, cin[7:0]}) * g0;
         wire signed [24:0] p1 = $signed({1'b0, cin[15:8]}) * g1;
         wire signed [24:0] p2 = $signed({1'b0, cin[23:16]}) * g2;
         // Offset r lands on output r after the product
         wire [27:0] acc = {{3{p0[24]}}, p0} + {{3{p1[24]}}, p1} + {{3{p2[24]}}, p2}
            + {{4{ofs[15]}}, ofs, 8'h00} + `PLM_ROUND;
         // Disabled unit passes the component through untouched
         always @(posedge i_clk or negedge i_rst_b)
         begin
            if (!i_rst_b)
               out_ff[r] <= 8'h00;
            else if (i_valid)
               out_ff[r] <= i_enable ? sat_pix(acc) : cin[r*8 +: 8];
         end
      end
   endgenerate

   // Valid is delayed one stage, in step with the data
   always @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_valid <= 1'b0;
      else
         o_valid <= i_valid;
   end

   assign o_c0 = out_ff[0];
   assign o_c1 = out_ff[1];
   assign o_c2 = out_ff[2];

endmodule

// ### verification/plm_pixel_core_props.sv
// Checker of the pixel core, watching only its top ports.
// Assumes a bind to a several-table build, one clock, one reset.
`timescale 1ns/1ps
`include "plm_map.vh"

module plm_pixel_core_props
(
   input wire I_CORE_CLK,
   input wire I_RST_B,
   input wire [`PLM_AW-1:0] I_REG_ADDR,
   input wire [`PLM_DW-1:0] I_REG_WDATA,
   input wire I_REG_WR,
   input wire I_REG_RD,
   input wire [`PLM_DW-1:0] O_REG_RDATA,
   input wire I_PIX_VALID,
   input wire [`PLM_PIX_W-1:0] I_PIX_C0,
   input wire [`PLM_PIX_W-1:0] I_PIX_C1,
   input wire [`PLM_PIX_W-1:0] I_PIX_C2,
   input wire O_PIX_VALID,
   input wire [`PLM_PIX_W-1:0] O_PIX_C0,
   input wire [`PLM_PIX_W-1:0] O_PIX_C1,
   input wire [`PLM_PIX_W-1:0] O_PIX_C2
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_B);

   // Write then immediate read of the table choice
   sequence s_wr_choice;
      I_REG_WR && I_REG_ADDR == `PLM_REG_TABLE_CHOICE;
   endsequence
   sequence s_rd_at(logic [`PLM_AW-1:0] a);
      I_REG_RD && I_REG_ADDR == a;
   endsequence

   property p_choice_back;
      s_wr_choice ##1 s_rd_at(`PLM_REG_TABLE_CHOICE) |=> O_REG_RDATA == {30'h0, $past(I_REG_WDATA[1:0], 2)};
   endproperty
   a_choice_back: assert property (p_choice_back) else $error("table choice readback wrong");
   // Read data only in the cycle after a read strobe
   property p_rd_idle;
      !$past(I_REG_RD) |-> O_REG_RDATA == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
   property p_word_narrow;
      s_rd_at(`PLM_REG_COEF_WORD) or (I_REG_RD && I_REG_ADDR[`PLM_BULK_BIT]) |=> O_REG_RDATA[31:8] == 24'h0;
   endproperty
   a_word_narrow: assert property (p_word_narrow) else $error("table entry wider than pixel");
   property p_status_narrow;
      s_rd_at(`PLM_REG_STATUS) |=> O_REG_RDATA[31:6] == 26'h0;
   endproperty
   a_status_narrow: assert property (p_status_narrow) else $error("status high bits set");
   property p_unit_narrow;
      s_rd_at(`PLM_REG_UNIT_CHOICE) |=> O_REG_RDATA[31:1] == 31'h0;
   endproperty
   a_unit_narrow: assert property (p_unit_narrow) else $error("unit choice high bits set");
   property p_elem_range;
      s_rd_at(`PLM_REG_ELEM_CHOICE) |=> O_REG_RDATA <= 32'h0000000B;
   endproperty
   a_elem_range: assert property (p_elem_range) else $error("element choice beyond last");
   property p_elem_sign;
      s_rd_at(`PLM_REG_ELEM_WORD) |=> O_REG_RDATA[31:16] == {16{O_REG_RDATA[15]}};
   endproperty
   a_elem_sign: assert property (p_elem_sign) else $error("element word not sign extended");
   // Each pixel out exactly four cycles on, and nothing else
   property p_pix_lat;
      I_PIX_VALID |-> ##4 O_PIX_VALID;
   endproperty
   a_pix_lat: assert property (p_pix_lat) else $error("pixel result missing");
   property p_pix_only;
      O_PIX_VALID |-> $past(I_PIX_VALID, 4);
   endproperty
   a_pix_only: assert property (p_pix_only) else $error("pixel result without input");
   property p_pix_hold;
      !O_PIX_VALID |-> $stable({O_PIX_C0, O_PIX_C1, O_PIX_C2});
   endproperty
   a_pix_hold: assert property (p_pix_hold) else $error("pixel data moved between results");
endmodule

// ### verification/plm_pix_src.sv
// Upstream pixel model: one RGB triplet per commanded cycle.
// Assumes the core clock and no back-pressure.
`timescale 1ns/1ps

module plm_pix_src
(
   input wire i_clk,
   input wire i_rst_b,
   input wire i_go,
   input wire [23:0] i_pix,
   output reg o_valid,
   output reg [7:0] o_c0,
   output reg [7:0] o_c1,
   output reg [7:0] o_c2
);
   // Idle data toggle every cycle so a design that ignores valid is caught
   always @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_valid <= 1'b0;
         {o_c0, o_c1, o_c2} <= 24'h000000;
      end
      else
      begin
         o_valid <= i_go;
         if (i_go)
            {o_c0, o_c1, o_c2} <= i_pix;
         else
            {o_c0, o_c1, o_c2} <= ~{o_c0, o_c1, o_c2};
      end
   end
endmodule

// ### verification/test_pixel_lut_and_color_matrix.sv
// Self-checking bench for the pixel core.
// Assumes a 10 MHz clock and the upstream pixel model.
`timescale 1ns/1ps
`include "plm_map.vh"
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin failures++; $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); end end

module test_pixel_lut_and_color_matrix;
   reg core_clk = 1'b0;
   reg rst_b = 1'b0;
   reg [10:0] addr = 11'h000;
   reg [31:0] wdata = 32'h00000000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg go = 1'b0;
   reg [23:0] pix = 24'h000000;
   wire [31:0] rdata;
   wire s_valid, o_valid;
   wire [7:0] s_c0, s_c1, s_c2, o_c0, o_c1, o_c2;
   int failures = 0;
   int n_compared = 0;
   logic [23:0] outq[$]; // Results in arrival order
   logic [15:0] cf[12] = '{16'h0080, 16'h0, 16'h0, 16'h0100, 16'h0, 16'hFF00, 16'h0, 16'h0, 16'h0100,
                           16'h0005, 16'h0, 16'h00FA};

   always #50 core_clk = ~core_clk;

   plm_pix_src plm_pix_src_inst (.i_clk(core_clk), .i_rst_b(rst_b), .i_go(go), .i_pix(pix),
      .o_valid(s_valid), .o_c0(s_c0), .o_c1(s_c1), .o_c2(s_c2));
   plm_pixel_core #(.SINGLE_TABLE(0)) plm_pixel_core_inst (.I_CORE_CLK(core_clk), .I_RST_B(rst_b),
      .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
      .I_PIX_VALID(s_valid), .I_PIX_C0(s_c0), .I_PIX_C1(s_c1), .I_PIX_C2(s_c2),
      .O_PIX_VALID(o_valid), .O_PIX_C0(o_c0), .O_PIX_C1(o_c1), .O_PIX_C2(o_c2));

   // Collect result pixels, each valid one cycle
   always @(posedge core_clk)
      if (o_valid === 1'b1)
         outq.push_back({o_c0, o_c1, o_c2});

   // Table content pattern, distinct per table
   function [7:0] lutv(input int t, input int i);
      lutv = 8'(i * (t + 3) + t * 17);
   endfunction

   task wr_reg(input [10:0] a, input [31:0] d);
      @(posedge core_clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   // Read, optionally right after a write with no gap between the strobes
   task rd_reg(input [10:0] a, input [31:0] ex, input string nm, input bit w = 1'b0, input [31:0] d = 32'h0);
      @(posedge core_clk);
      wr <= w; rd <= !w; addr <= a; wdata <= d;
      if (w)
      begin
         @(posedge core_clk);
         wr <= 1'b0; rd <= 1'b1;
      end
      @(posedge core_clk);
      rd <= 1'b0;
      #1 `CHK(nm, ex, rdata)
   endtask
   task send2(input [23:0] p, input [23:0] q, input bit two);
      @(posedge core_clk);
      go <= 1'b1; pix <= p;
      if (two)
      begin
         @(posedge core_clk);
         pix <= q;
      end
      @(posedge core_clk);
      go <= 1'b0;
   endtask
   // Bounded wait for the next result pixel
   task take(input [23:0] ex, input string nm);
      logic [23:0] got;
      for (int k = 0; k < 30 && outq.size() == 0; k++)
         @(posedge core_clk);
      got = (outq.size() != 0) ? outq.pop_front() : 24'hxxxxxx;
      `CHK(nm, ex, got)
   endtask

   task t_reset;
      rd_reg(`PLM_REG_TABLE_CHOICE, 32'h0, "choice");
      rd_reg(`PLM_REG_STATUS, 32'h0, "status");
      rd_reg(`PLM_REG_ELEM_WORD, 32'h100, "rgb gain");
      wr_reg(`PLM_REG_ELEM_CHOICE, 32'h1);
      rd_reg(`PLM_REG_ELEM_WORD, 32'h0, "rgb off-diag");
      wr_reg(`PLM_REG_UNIT_CHOICE, 32'h1);
      rd_reg(`PLM_REG_ELEM_WORD, 32'h4D, "luma gain");
      wr_reg(`PLM_REG_ELEM_CHOICE, 32'hA);
      rd_reg(`PLM_REG_ELEM_WORD, 32'h80, "chroma add");
      rd_reg(`PLM_REG_ELEM_CHOICE, 32'hA, "choice refused", 1'b1, 32'hC);
      wr_reg(`PLM_REG_UNIT_CHOICE, 32'h0);
      rd_reg(`PLM_REG_ELEM_CHOICE, 32'h1, "own choice");
      rd_reg(11'h024, 32'h0, "unmapped");
      $display("test t_reset done");
   endtask

   task t_lut;
      for (int t = 0; t < 4; t++)
      begin
         rd_reg(`PLM_REG_TABLE_CHOICE, t, "choice", 1'b1, t);
         for (int i = 0; i < 256; i++)
            wr_reg(11'h400 | 11'(i << 2), lutv(t, i));
         wr_reg(`PLM_REG_COEF_POSITION, t + 5);
      end
      for (int t = 0; t < 4; t++)
      begin
         wr_reg(`PLM_REG_TABLE_CHOICE, t);
         rd_reg(`PLM_REG_COEF_WORD, lutv(t, t + 5), "word");
         rd_reg(11'h720, lutv(t, 200), "window");
      end
      wr_reg(`PLM_REG_TABLE_CHOICE, 32'h2);
      wr_reg(`PLM_REG_COEF_WORD, 32'hA5);
      rd_reg(11'h41C, 32'hA5, "word write");
      rd_reg(`PLM_REG_COEF_POSITION, 32'h7, "position kept");
      wr_reg(`PLM_REG_COEF_WORD, lutv(2, 7));
      $display("test t_lut done");
   endtask

   task t_pix_lut;
      wr_reg(`PLM_REG_TABLE_CHOICE, 32'h0);
      wr_reg(`PLM_REG_TABLE_ACTIVATE, 32'h1);
      send2(24'h030405, 24'h00FF09, 1'b1);
      take({lutv(0, 3), lutv(0, 4), lutv(0, 5)}, "luma map");
      take({lutv(0, 0), lutv(0, 255), lutv(0, 9)}, "luma map 2");
      wr_reg(`PLM_REG_TABLE_CHOICE, 32'h1);
      wr_reg(`PLM_REG_TABLE_ACTIVATE, 32'h1);
      rd_reg(`PLM_REG_STATUS, 32'h3, "status");
      send2(24'h030405, 24'h0, 1'b0);
      take({lutv(1, lutv(0, 3)), lutv(0, 4), lutv(0, 5)}, "red map");
      wr_reg(`PLM_REG_TABLE_ACTIVATE, 32'h0);
      wr_reg(`PLM_REG_TABLE_CHOICE, 32'h0);
      wr_reg(`PLM_REG_TABLE_ACTIVATE, 32'h0);
      send2(24'h030405, 24'h0, 1'b0);
      take(24'h030405, "pass");
      $display("test t_pix_lut done");
   endtask

   task t_matrix;
      for (int k = 0; k < 12; k++)
      begin
         wr_reg(`PLM_REG_ELEM_CHOICE, k);
         wr_reg(`PLM_REG_ELEM_WORD, {16'h0, cf[k]});
      end
      wr_reg(`PLM_REG_ELEM_CHOICE, 32'h5);
      rd_reg(`PLM_REG_ELEM_WORD, 32'hFFFFFF00, "negative gain");
      wr_reg(`PLM_REG_UNIT_ACTIVATE, 32'h1);
      send2(24'h290709, 24'h000009, 1'b1);
      take(24'h1A20FF, "matrix");
      take(24'h0500FF, "clamp");
      $display("test t_matrix done");
   endtask

   task t_yuv;
      wr_reg(`PLM_REG_UNIT_ACTIVATE, 32'h0);
      wr_reg(`PLM_REG_UNIT_CHOICE, 32'h1);
      wr_reg(`PLM_REG_UNIT_ACTIVATE, 32'h1);
      rd_reg(`PLM_REG_STATUS, 32'h20, "unit status");
      send2(24'hFFFFFF, 24'h0, 1'b0);
      take(24'hFF807F, "luma chroma");
      wr_reg(`PLM_REG_UNIT_CHOICE, 32'h0);
      wr_reg(`PLM_REG_UNIT_ACTIVATE, 32'h1);
      send2(24'hFFFFFF, 24'h0, 1'b0);
      take(24'h45DCB8, "series");
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rd_reg(`PLM_REG_STATUS, 32'h0, "second reset");
      $display("test t_yuv done");
   endtask

   task summarize;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Run needs about 2300 cycles; allow several times that
   initial
   begin
      #2000000;
      failures++;
      $display("watchdog expired");
      summarize();
   end

   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset();
      t_lut();
      t_pix_lut();
      t_matrix();
      t_yuv();
      summarize();
   end
endmodule

bind plm_pixel_core plm_pixel_core_props plm_pixel_core_props_inst (.*);
